// ===== logic/status_service_request.v
// Status groups, status byte and service request mask
`timescale 1ns/10ps
`include "status_sr_defs.vh"

module status_service_request #(
    parameter GRP_W = 16
) (
    input  wire             ref_clk_in,
    input  wire             rst_n_in,
    input  wire             clk_en_in,
    input  wire [GRP_W-1:0] oper_cond_in,
    input  wire [GRP_W-1:0] ques_cond_in,
    input  wire [7:0]       std_event_in,
    input  wire             err_queue_nonempty_in,
    input  wire             msg_available_in,
    input  wire             wr_en_in,
    input  wire             rd_en_in,
    input  wire             clear_status_in,
    input  wire [3:0]       reg_sel_in,
    input  wire [GRP_W-1:0] wr_data_in,
    output reg  [GRP_W-1:0] rd_data_out,
    output wire [7:0]       status_byte_out,
    output reg              service_request_out
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg [GRP_W-1:0] oper_s1;
    reg [GRP_W-1:0] oper_s2;
    reg [GRP_W-1:0] ques_s1;
    reg [GRP_W-1:0] ques_s2;
    reg [7:0]       std_s1;
    reg [7:0]       std_s2;
    reg [1:0]       misc_s1;
    reg [1:0]       misc_s2;

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            oper_s1 <= {GRP_W{1'b0}};
            oper_s2 <= {GRP_W{1'b0}};
            ques_s1 <= {GRP_W{1'b0}};
            ques_s2 <= {GRP_W{1'b0}};
            std_s1  <= 8'h00;
            std_s2  <= 8'h00;
            misc_s1 <= 2'h0;
            misc_s2 <= 2'h0;
        end else if (clk_en_in) begin
            oper_s1 <= oper_cond_in;
            oper_s2 <= oper_s1;
            ques_s1 <= ques_cond_in;
            ques_s2 <= ques_s1;
            std_s1  <= std_event_in;
            std_s2  <= std_s1;
            misc_s1 <= {msg_available_in, err_queue_nonempty_in};
            misc_s2 <= misc_s1;
        end
    end

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    function sel_hit;
        input [3:0] sel;
        input [3:0] target;
        begin
            sel_hit = (sel == target);
        end
    endfunction

    wire wr_mask   = wr_en_in && sel_hit(reg_sel_in, `REG_SRQ_MASK);
    wire wr_std_en = wr_en_in && sel_hit(reg_sel_in, `REG_STD_ENABLE);
    wire rd_std_ev = rd_en_in && sel_hit(reg_sel_in, `REG_STD_EVENT);

    // ------------------------------------------------------------
    // Operation and questionable groups
    // ------------------------------------------------------------
    wire [GRP_W-1:0] cond_s [0:1];
    wire [1:0]       grp_summary;
    wire [GRP_W-1:0] grp_cond  [0:1];
    wire [GRP_W-1:0] grp_neg   [0:1];
    wire [GRP_W-1:0] grp_pos   [0:1];
    wire [GRP_W-1:0] grp_event [0:1];
    wire [GRP_W-1:0] grp_en    [0:1];

    assign cond_s[0] = oper_s2;
    assign cond_s[1] = ques_s2;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : grp
            localparam [3:0] BASE = (g == 0) ? `REG_OPER_COND : `REG_QUES_COND;
            reg [GRP_W-1:0] prev;
            reg [GRP_W-1:0] neg_f;
            reg [GRP_W-1:0] pos_f;
            reg [GRP_W-1:0] event_r;
            reg [GRP_W-1:0] enable_r;
            wire [GRP_W-1:0] rise = cond_s[g] & ~prev;
            wire [GRP_W-1:0] fall = ~cond_s[g] & prev;
            wire [GRP_W-1:0] hits = (rise & pos_f)
                                  | (fall & neg_f);
            wire rd_ev = rd_en_in && sel_hit(reg_sel_in, BASE + 4'h3);
            always @(posedge ref_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    prev     <= {GRP_W{1'b0}};
                    neg_f    <= `GRP_NEG_RST;
                    pos_f    <= `GRP_POS_RST;
                    event_r  <= {GRP_W{1'b0}};
                    enable_r <= `GRP_ENABLE_RST;
                end else if (clk_en_in) begin
                    prev <= cond_s[g];
                    // Set wins over a clear in the same cycle
                    if (rd_ev || clear_status_in) begin
                        event_r <= hits;
                    end else begin
                        event_r <= event_r | hits;
                    end
                    if (wr_en_in && sel_hit(reg_sel_in, BASE + 4'h1)) begin
                        neg_f <= wr_data_in;
                    end
                    if (wr_en_in && sel_hit(reg_sel_in, BASE + 4'h2)) begin
                        pos_f <= wr_data_in;
                    end
                    if (wr_en_in && sel_hit(reg_sel_in, BASE + 4'h4)) begin
                        enable_r <= wr_data_in;
                    end
                end
            end
            assign grp_summary[g] = |(event_r & enable_r);
            assign grp_cond[g]    = cond_s[g];
            assign grp_neg[g]     = neg_f;
            assign grp_pos[g]     = pos_f;
            assign grp_event[g]   = event_r;
            assign grp_en[g]      = enable_r;
        end
    endgenerate

    // ------------------------------------------------------------
    // Standard event group
    // ------------------------------------------------------------
    reg  [7:0] std_event;
    reg  [7:0] std_enable;
    wire       std_summary = |(std_event & std_enable);

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            std_event  <= 8'h00;
            std_enable <= `STD_ENABLE_RST;
        end else if (clk_en_in) begin
            if (rd_std_ev || clear_status_in) begin
                std_event <= std_s2;
            end else begin
                std_event <= std_event | std_s2;
            end
            if (wr_std_en) begin
                std_enable <= wr_data_in[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Service request mask and status byte
    // ------------------------------------------------------------
    reg  [7:0] srq_mask;
    wire [7:0] sb_low;
    wire       rqs_bit;

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            srq_mask <= `SRQ_MASK_RST;
        end else if (clk_en_in && wr_mask) begin
            srq_mask <= wr_data_in[7:0] & `SRQ_MASK_FIXED;
        end
    end

    assign sb_low = {grp_summary[0], 1'b0, std_summary,
                     misc_s2[1], grp_summary[1], misc_s2[0], 2'b00};
    assign rqs_bit = |(sb_low & srq_mask);
    assign status_byte_out = {sb_low[7], rqs_bit, sb_low[5:0]};

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            service_request_out <= 1'b0;
        end else if (clk_en_in) begin
            service_request_out <= rqs_bit;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= {GRP_W{1'b0}};
        end else if (clk_en_in && rd_en_in) begin
            case (reg_sel_in)
                `REG_SRQ_MASK:    rd_data_out <= {{(GRP_W-8){1'b0}}, srq_mask};
                `REG_STATUS_BYTE: rd_data_out <= {{(GRP_W-8){1'b0}}, status_byte_out};
                `REG_STD_EVENT:   rd_data_out <= {{(GRP_W-8){1'b0}}, std_event};
                `REG_STD_ENABLE:  rd_data_out <= {{(GRP_W-8){1'b0}}, std_enable};
                `REG_OPER_COND:   rd_data_out <= grp_cond[0];
                `REG_OPER_NEG:    rd_data_out <= grp_neg[0];
                `REG_OPER_POS:    rd_data_out <= grp_pos[0];
                `REG_OPER_EVENT:  rd_data_out <= grp_event[0];
                `REG_OPER_ENABLE: rd_data_out <= grp_en[0];
                `REG_QUES_COND:   rd_data_out <= grp_cond[1];
                `REG_QUES_NEG:    rd_data_out <= grp_neg[1];
                `REG_QUES_POS:    rd_data_out <= grp_pos[1];
                `REG_QUES_EVENT:  rd_data_out <= grp_event[1];
                `REG_QUES_ENABLE: rd_data_out <= grp_en[1];
                default:          rd_data_out <= {GRP_W{1'b0}};
            endcase
        end
    end

endmodule

// ===== logic/status_sr_defs.vh
// Constants for the status group and service request block
`ifndef STATUS_SR_DEFS_VH
`define STATUS_SR_DEFS_VH

// ------------------------------------------------------------
// Register selects
// ------------------------------------------------------------
`define REG_SRQ_MASK      4'h0
`define REG_STATUS_BYTE   4'h1
`define REG_STD_EVENT     4'h2
`define REG_STD_ENABLE    4'h3
`define REG_OPER_COND     4'h4
`define REG_OPER_NEG      4'h5
`define REG_OPER_POS      4'h6
`define REG_OPER_EVENT    4'h7
`define REG_OPER_ENABLE   4'h8
`define REG_QUES_COND     4'h9
`define REG_QUES_NEG      4'ha
`define REG_QUES_POS      4'hb
`define REG_QUES_EVENT    4'hc
`define REG_QUES_ENABLE   4'hd

// ------------------------------------------------------------
// Status byte bit positions
// ------------------------------------------------------------
`define SB_ERRQ_BIT       2
`define SB_QUES_BIT       3
`define SB_MAV_BIT        4
`define SB_STD_BIT        5
`define SB_RQS_BIT        6
`define SB_OPER_BIT       7

// ------------------------------------------------------------
// Reset values and the writable bits of the service request mask
// ------------------------------------------------------------
`define SRQ_MASK_RST      8'h00
`define STD_ENABLE_RST    8'h00
`define GRP_ENABLE_RST    16'h0000
`define GRP_NEG_RST       16'h0000
`define GRP_POS_RST       16'h7fff
`define SRQ_MASK_FIXED    8'hbf

`endif

// ===== test/status_sr_chk.sv
// Checker for the status byte and service request outputs
`timescale 1ns/10ps
module status_sr_chk #(
    parameter GRP_W = 16
) (
    input logic             ref_clk_in,
    input logic             rst_n_in,
    input logic             clk_en_in,
    input logic             err_queue_nonempty_in,
    input logic             wr_en_in,
    input logic             rd_en_in,
    input logic [3:0]       reg_sel_in,
    input logic [GRP_W-1:0] wr_data_in,
    input logic [GRP_W-1:0] rd_data_out,
    input logic [7:0]       status_byte_out,
    input logic             service_request_out
);
    logic [7:0] mask;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Shadow of the mask as the host last set it
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask <= 8'h00;
        end else if (clk_en_in && wr_en_in && reg_sel_in == 4'h0) begin
            mask <= wr_data_in[7:0] & 8'hbf;
        end
    end
    sequence s_rd(s);
        clk_en_in && rd_en_in && reg_sel_in == s;
    endsequence
    a_rqs_summary: assert property (status_byte_out[6] == |(status_byte_out & mask))
        else $error("status bit 6 disagrees with masked bits");
    a_srq_follow: assert property (clk_en_in |=> service_request_out == $past(status_byte_out[6]))
        else $error("service request does not follow bit 6");
    a_mask_read: assert property (s_rd(4'h0) |=> rd_data_out == {8'h00, $past(mask)})
        else $error("mask read wrong");
    a_byte_read: assert property (s_rd(4'h1) |=> rd_data_out == {8'h00, $past(status_byte_out)})
        else $error("status byte read wrong");
    a_unmapped_zero: assert property (clk_en_in && rd_en_in && reg_sel_in > 4'hd |=> rd_data_out == 0)
        else $error("unmapped read not zero");
    a_data_holds: assert property (!(clk_en_in && rd_en_in) |=> $stable(rd_data_out))
        else $error("read data changed without a read");
    a_spare_zero: assert property (status_byte_out[1:0] == 2'b00)
        else $error("unused status bits set");
    a_errq_track: assert property ($rose(err_queue_nonempty_in) |-> ##[1:4] status_byte_out[2])
        else $error("error queue bit late");
endmodule
bind status_service_request status_sr_chk #(.GRP_W(GRP_W)) chk (
    .ref_clk_in, .rst_n_in, .clk_en_in, .err_queue_nonempty_in, .wr_en_in, .rd_en_in,
    .reg_sel_in, .wr_data_in, .rd_data_out, .status_byte_out, .service_request_out
);

// ===== test/status_host_model.sv
// Remote host model issuing register commands
`timescale 1ns/10ps
module status_host_model (
    input  logic        ref_clk_in,
    input  logic [15:0] rd_data_in,
    output logic        wr_en_out = 1'b0,
    output logic        rd_en_out = 1'b0,
    output logic        clear_out = 1'b0,
    output logic [3:0]  sel_out   = 4'h0,
    output logic [15:0] data_out  = 16'h0000
);
    // Value is the weighted sum of the bits to enable
    task automatic write_reg(input logic [3:0] s, input logic [15:0] d);
        @(posedge ref_clk_in);
        sel_out   <= s;
        data_out  <= d;
        wr_en_out <= 1'b1;
        @(posedge ref_clk_in);
        wr_en_out <= 1'b0;
        data_out  <= ~d;
    endtask
    task automatic read_reg(input logic [3:0] s, output logic [15:0] d);
        @(posedge ref_clk_in);
        sel_out   <= s;
        rd_en_out <= 1'b1;
        @(posedge ref_clk_in);
        rd_en_out <= 1'b0;
        @(posedge ref_clk_in);
        d = rd_data_in;
    endtask
    task automatic clear_status;
        @(posedge ref_clk_in);
        clear_out <= 1'b1;
        @(posedge ref_clk_in);
        clear_out <= 1'b0;
    endtask
endmodule

// ===== test/status_service_request_test.sv
// Self-checking bench for the status service request block
`timescale 1ns/10ps
module status_service_request_test;
    logic        ref_clk_in = 1'b0;
    logic        rst_n_in   = 1'b0;
    logic [15:0] oper       = 16'h0000;
    logic [15:0] ques       = 16'h0000;
    logic [7:0]  std_ev     = 8'h00;
    logic        errq       = 1'b0;
    logic        msg        = 1'b0;
    logic        clk_en     = 1'b1;
    logic        wr_en, rd_en, clr, srq;
    logic [3:0]  sel;
    logic [15:0] wdata, rdata;
    logic [7:0]  sbyte;
    int          err_total  = 0;
    int          compares   = 0;
    status_host_model host (.ref_clk_in(ref_clk_in), .rd_data_in(rdata), .wr_en_out(wr_en),
        .rd_en_out(rd_en), .clear_out(clr), .sel_out(sel), .data_out(wdata));
    status_service_request #(.GRP_W(16)) uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .clk_en_in(clk_en), .oper_cond_in(oper), .ques_cond_in(ques), .std_event_in(std_ev),
        .err_queue_nonempty_in(errq), .msg_available_in(msg), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .clear_status_in(clr), .reg_sel_in(sel), .wr_data_in(wdata),
        .rd_data_out(rdata), .status_byte_out(sbyte), .service_request_out(srq));
    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [3:0] s, input logic [15:0] exp);
        logic [15:0] v;
        host.read_reg(s, v);
        chk(v, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic end_of_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk_in);
        err_total++;
        $display("MISMATCH %0t timeout", $time);
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rd_chk(4'h6, 16'h7fff);
        host.write_reg(4'h0, 16'hffff);
        rd_chk(4'h0, 16'h00bf);
        host.write_reg(4'h0, 16'h00a0);
        rd_chk(4'h0, 16'h00a0);
        @(posedge ref_clk_in);
        oper <= 16'h0008;
        settle(5);
        rd_chk(4'h4, 16'h0008);
        chk({8'h00, sbyte}, 16'h0000);
        host.write_reg(4'h8, 16'h0008);
        settle(2);
        chk({8'h00, sbyte}, 16'h00c0);
        chk({15'h0000, srq}, 16'h0001);
        rd_chk(4'h1, 16'h00c0);
        rd_chk(4'h7, 16'h0008);
        rd_chk(4'h7, 16'h0000);
        settle(1);
        chk({15'h0000, srq}, 16'h0000);
        @(posedge ref_clk_in);
        oper <= 16'h8008;
        settle(5);
        rd_chk(4'h7, 16'h0000);
        host.write_reg(4'h5, 16'h0008);
        oper <= 16'h8000;
        settle(5);
        rd_chk(4'h7, 16'h0008);
        host.write_reg(4'h3, 16'h0001);
        std_ev <= 8'h01;
        @(posedge ref_clk_in);
        std_ev <= 8'h00;
        settle(5);
        chk({8'h00, sbyte}, 16'h0060);
        host.clear_status();
        settle(2);
        rd_chk(4'h2, 16'h0000);
        host.write_reg(4'hd, 16'h0001);
        errq <= 1'b1;
        msg  <= 1'b1;
        ques <= 16'h0001;
        settle(6);
        chk({8'h00, sbyte}, 16'h001c);
        host.write_reg(4'h0, 16'h001c);
        settle(2);
        chk({8'h00, sbyte}, 16'h005c);
        // Write while frozen must be ignored
        @(posedge ref_clk_in);
        clk_en <= 1'b0;
        host.write_reg(4'h0, 16'h0000);
        clk_en <= 1'b1;
        rd_chk(4'h0, 16'h001c);
        rd_chk(4'hf, 16'h0000);
        end_of_test();
    end
endmodule
